/* File: logic/cmf_mailbox.v */
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "cmf_map.vh"

module cmf_mailbox #(
  parameter NUM_MB = 8
) (
  input  wire        SYS_CLK_I,
  input  wire        SRST_I,
  input  wire [11:0] ADR_I,
  input  wire [31:0] DAT_I,
  input  wire [3:0]  SEL_I,
  input  wire        WE_I,
  input  wire        CYC_I,
  input  wire        STB_I,
  output reg  [31:0] DAT_O,
  output reg         ACK_O,
  input  wire [15:0] TIMER_I,
  input  wire        FRAME_SOF_I,
  input  wire        RX_VALID_I,
  input  wire [28:0] RX_ID_I,
  input  wire        RX_IDE_I,
  input  wire        RX_RTR_I,
  input  wire [3:0]  RX_DLC_I,
  input  wire        TX_DONE_I,
  input  wire [2:0]  TX_MB_I,
  output reg  [7:0]  TX_REQ_O,
  output reg  [7:0]  TX_RTR_O,
  output reg  [7:0]  MB_READY_O,
  output reg         MB_IRQ_O,
  output reg         RX_STORE_O,
  output reg  [2:0]  RX_STORE_MB_O
);

  reg [2:0]  obj_type [0:NUM_MB-1];
  reg [29:0] acc_mask [0:NUM_MB-1];
  reg [29:0] mb_id    [0:NUM_MB-1];
  reg [29:0] sn_mask  [0:NUM_MB-1];
  reg [29:0] sn_id    [0:NUM_MB-1];
  reg [3:0]  len_code [0:NUM_MB-1];
  reg [15:0] stamp    [0:NUM_MB-1];
  reg [NUM_MB-1:0] ready;
  reg [NUM_MB-1:0] abort;
  reg [NUM_MB-1:0] ignored;
  reg [NUM_MB-1:0] rtr_flag;
  reg [NUM_MB-1:0] armed;
  reg [NUM_MB-1:0] waiting;
  reg        time_trigger_enable;
  reg        eof_capture_sel;
  reg [15:0] sof_time;
  reg        flt_busy;
  reg [28:0] flt_id;
  reg        flt_ide;
  reg        flt_rtr;
  reg [3:0]  flt_dlc;
  reg [NUM_MB-1:0] hit;
  reg [NUM_MB-1:0] can_take;
  reg        next_win;
  reg [2:0]  next_win_mb;
  reg [31:0] next_rdata;
  integer    i;
  // separate index for the filter loop so the clocked loop variable has one driver
  integer    f;

  wire       bus_req = CYC_I & STB_I & ~ACK_O;
  wire       bus_wr  = bus_req & WE_I;
  wire       bus_rd  = bus_req & ~WE_I;
  wire       is_glob = ADR_I[8];
  wire [2:0] adr_mb  = ADR_I[7:5];
  wire [4:0] adr_ofs = ADR_I[4:0];
  wire       mb_ok   = ~is_glob & ({1'b0, adr_mb} < NUM_MB) & (ADR_I[11:9] == 3'h0);
  wire [31:0] be     = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
  wire [31:0] wcmd   = DAT_I & be;
  wire [15:0] ts_now = time_trigger_enable ? 16'h0000 :
                       (eof_capture_sel ? TIMER_I : sof_time);

  function [29:0] merge;
    input [29:0] old;
    input [29:0] nw;
    input [29:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  // reserved codes fall out here, so they act like disabled
  function active;
    input [2:0] t;
    begin
      active = (t != `CMF_OT_DISABLED) && (t <= `CMF_OT_PRODUCER);
    end
  endfunction

  // extended part reads zero for standard identifiers
  function [29:0] clip_ext;
    input [29:0] v;
    begin
      clip_ext = v[`CMF_VER_BIT] ? v : {v[29:18], 18'h00000};
    end
  endfunction

  function id_match;
    input [29:0] m;
    input [29:0] id;
    input [28:0] rid;
    input        ride;
    reg   [28:0] diff;
    begin
      diff = (rid ^ id[28:0]) & m[28:0];
      id_match = (id[`CMF_VER_BIT] == ride) &&
                 (diff[`CMF_BASE_MSB:`CMF_BASE_LSB] == 11'h000) &&
                 (!m[`CMF_VER_BIT] || (diff[`CMF_EXT_MSB:0] == 18'h00000));
    end
  endfunction

  function [28:0] family;
    input [29:0] id;
    input [29:0] m;
    integer      j;
    integer      k;
    begin
      family = 29'h00000000;
      k = 0;
      for (j = 0; j < 29; j = j + 1) begin
        if (m[j]) begin
          family[k] = id[j];
          k = k + 1;
        end
      end
    end
  endfunction

  // filter stage: works on mask and id snapshots so live writes to those registers cannot race it; type and flags are read live
  always @* begin
    hit      = {NUM_MB{1'b0}};
    can_take = {NUM_MB{1'b0}};
    next_win = 1'b0;
    next_win_mb = 3'h0;
    for (f = NUM_MB - 1; f >= 0; f = f - 1) begin
      hit[f] = flt_busy && active(obj_type[f]) && id_match(sn_mask[f], sn_id[f], flt_id, flt_ide);
      case (obj_type[f])
        `CMF_OT_RX: can_take[f] = hit[f] & ~ready[f];
        `CMF_OT_RX_OVWR: can_take[f] = hit[f];
        `CMF_OT_CONSUMER: can_take[f] = hit[f] & waiting[f] & ~ready[f] & ~flt_rtr;
        default: can_take[f] = 1'b0;
      endcase
      if (can_take[f]) begin
        next_win = 1'b1;
        next_win_mb = f[2:0];
      end
    end
  end

  always @* begin
    next_rdata = `CMF_RST_WORD;
    if (is_glob && ADR_I == `CMF_ADR_CTRL_MODE) begin
      next_rdata[`CMF_MD_TTM] = time_trigger_enable;
      next_rdata[`CMF_MD_EOF] = eof_capture_sel;
    end else if (mb_ok) begin
      case (adr_ofs)
        `CMF_OFS_MODE:
          next_rdata[`CMF_TYPE_LSB+2:`CMF_TYPE_LSB] = obj_type[adr_mb];
        `CMF_OFS_MASK: next_rdata[29:0] = acc_mask[adr_mb];
        `CMF_OFS_ID: next_rdata[29:0] = mb_id[adr_mb];
        `CMF_OFS_FAMILY: next_rdata[28:0] = family(mb_id[adr_mb], acc_mask[adr_mb]);
        `CMF_OFS_STATUS: begin
          next_rdata[`CMF_ST_IGNORED] = ignored[adr_mb];
          next_rdata[`CMF_ST_READY]   = ready[adr_mb];
          next_rdata[`CMF_ST_ABORT]   = abort[adr_mb];
          next_rdata[`CMF_ST_RTR]     = rtr_flag[adr_mb];
          next_rdata[`CMF_ST_DLC_LSB+3:`CMF_ST_DLC_LSB] = len_code[adr_mb];
          next_rdata[15:0] = stamp[adr_mb];
        end
        default: next_rdata = `CMF_RST_WORD;
      endcase
    end
  end

  // wishbone answer: ack one cycle after the request, unmapped reads give zero
  always @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      ACK_O <= 1'b0;
      DAT_O <= `CMF_RST_WORD;
    end else begin
      ACK_O <= bus_req;
      if (bus_rd) begin
        DAT_O <= next_rdata;
      end
    end
  end

  always @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      time_trigger_enable <= 1'b0;
      eof_capture_sel     <= 1'b0;
      sof_time            <= 16'h0000;
      flt_busy            <= 1'b0;
      flt_id              <= 29'h00000000;
      flt_ide             <= 1'b0;
      flt_rtr             <= 1'b0;
      flt_dlc             <= 4'h0;
      ready               <= {NUM_MB{1'b0}};
      abort               <= {NUM_MB{1'b0}};
      ignored             <= {NUM_MB{1'b0}};
      rtr_flag            <= {NUM_MB{1'b0}};
      armed               <= {NUM_MB{1'b0}};
      waiting             <= {NUM_MB{1'b0}};
      TX_REQ_O            <= 8'h00;
      TX_RTR_O            <= 8'h00;
      MB_READY_O          <= 8'h00;
      MB_IRQ_O            <= 1'b0;
      RX_STORE_O          <= 1'b0;
      RX_STORE_MB_O       <= 3'h0;
      for (i = 0; i < NUM_MB; i = i + 1) begin
        obj_type[i] <= `CMF_OT_DISABLED;
        acc_mask[i] <= 30'h00000000;
        mb_id[i]    <= 30'h00000000;
        sn_mask[i]  <= 30'h00000000;
        sn_id[i]    <= 30'h00000000;
        len_code[i] <= 4'h0;
        stamp[i]    <= 16'h0000;
      end
    end else begin
      if (FRAME_SOF_I) begin
        sof_time <= TIMER_I;
      end
      flt_busy <= RX_VALID_I;
      if (RX_VALID_I) begin
        flt_id  <= RX_ID_I;
        flt_ide <= RX_IDE_I;
        flt_rtr <= RX_RTR_I;
        flt_dlc <= RX_DLC_I;
        for (i = 0; i < NUM_MB; i = i + 1) begin
          sn_mask[i] <= acc_mask[i];
          sn_id[i]   <= mb_id[i];
        end
      end
      RX_STORE_O    <= next_win;
      RX_STORE_MB_O <= next_win_mb;

      // software side first, so hardware events below win in the same cycle
      if (bus_wr && is_glob && ADR_I == `CMF_ADR_CTRL_MODE) begin
        if (SEL_I[0]) begin
          time_trigger_enable <= DAT_I[`CMF_MD_TTM];
          eof_capture_sel     <= DAT_I[`CMF_MD_EOF];
        end
      end
      for (i = 0; i < NUM_MB; i = i + 1) begin
        if (bus_rd && mb_ok && adr_mb == i[2:0] && adr_ofs == `CMF_OFS_STATUS) begin
          ignored[i] <= 1'b0;
        end
        if (bus_wr && mb_ok && adr_mb == i[2:0]) begin
          case (adr_ofs)
            `CMF_OFS_MODE: begin
              if (SEL_I[3]) begin
                obj_type[i] <= DAT_I[`CMF_TYPE_LSB+2:`CMF_TYPE_LSB];
                TX_REQ_O[i] <= 1'b0;
                armed[i]    <= 1'b0;
                waiting[i]  <= 1'b0;
                abort[i]    <= 1'b0;
                ready[i]    <= (DAT_I[`CMF_TYPE_LSB+2:`CMF_TYPE_LSB] == `CMF_OT_TX) ||
                               (DAT_I[`CMF_TYPE_LSB+2:`CMF_TYPE_LSB] == `CMF_OT_PRODUCER);
                if (DAT_I[`CMF_TYPE_LSB+2:`CMF_TYPE_LSB] == `CMF_OT_CONSUMER) begin
                  rtr_flag[i] <= 1'b1;
                end else if (DAT_I[`CMF_TYPE_LSB+2:`CMF_TYPE_LSB] == `CMF_OT_PRODUCER) begin
                  rtr_flag[i] <= 1'b0;
                end
              end
            end
            `CMF_OFS_MASK: acc_mask[i] <= merge(acc_mask[i], DAT_I[29:0], be[29:0]);
            `CMF_OFS_ID: mb_id[i] <= clip_ext(merge(mb_id[i], DAT_I[29:0], be[29:0]));
            `CMF_OFS_CTRL: begin
              if (wcmd[`CMF_CT_TRANSFER] && active(obj_type[i])) begin
                ready[i] <= 1'b0;
                abort[i] <= 1'b0;
                case (obj_type[i])
                  `CMF_OT_TX: TX_REQ_O[i] <= 1'b1;
                  `CMF_OT_CONSUMER: begin
                    TX_REQ_O[i] <= 1'b1;
                    waiting[i]  <= 1'b0;
                  end
                  `CMF_OT_PRODUCER: begin
                    armed[i]    <= 1'b1;
                    len_code[i] <= DAT_I[`CMF_CT_DLC_LSB+3:`CMF_CT_DLC_LSB];
                  end
                  default: armed[i] <= 1'b0;
                endcase
              end else if (wcmd[`CMF_CT_ABORT]) begin
                ready[i] <= 1'b0;
                abort[i] <= 1'b0;
                if (TX_REQ_O[i] || armed[i]) begin
                  abort[i]    <= 1'b1;
                  TX_REQ_O[i] <= 1'b0;
                  armed[i]    <= 1'b0;
                end
              end
            end
            default: armed[i] <= armed[i];
          endcase
        end

        if (active(obj_type[i])) begin
          if (hit[i] && can_take[i] && next_win_mb == i[2:0]) begin
            ready[i]    <= 1'b1;
            len_code[i] <= flt_dlc;
            if (obj_type[i] != `CMF_OT_CONSUMER) begin
              rtr_flag[i] <= flt_rtr;
            end
            stamp[i] <= ts_now;
            if (obj_type[i] == `CMF_OT_RX_OVWR && ready[i]) begin
              ignored[i] <= 1'b1;
            end
            if (obj_type[i] == `CMF_OT_CONSUMER) begin
              waiting[i] <= 1'b0;
            end
          end else if (hit[i] && ready[i] &&
                       (obj_type[i] == `CMF_OT_RX || obj_type[i] == `CMF_OT_CONSUMER)) begin
            ignored[i] <= 1'b1;
          end
          if (hit[i] && flt_rtr && obj_type[i] == `CMF_OT_PRODUCER) begin
            if (armed[i]) begin
              TX_REQ_O[i] <= 1'b1;
              armed[i]    <= 1'b0;
            end else begin
              ignored[i] <= 1'b1;
            end
          end
          if (TX_DONE_I && TX_MB_I == i[2:0] && TX_REQ_O[i]) begin
            TX_REQ_O[i] <= 1'b0;
            stamp[i]    <= ts_now;
            if (obj_type[i] == `CMF_OT_CONSUMER) begin
              waiting[i] <= 1'b1;
            end else begin
              ready[i] <= 1'b1;
            end
          end
        end
        if (time_trigger_enable) begin
          stamp[i] <= 16'h0000;
        end
        TX_RTR_O[i] <= (obj_type[i] == `CMF_OT_CONSUMER);
      end
      // ready drives data unlock; ready or abort drives request
      MB_READY_O <= ready;
      MB_IRQ_O   <= |(ready | abort);
    end
  end

endmodule // cmf_mailbox

/* File: logic/cmf_map.vh */
`ifndef CMF_MAP_VH
`define CMF_MAP_VH

// per-mailbox register window: mailbox n sits at n * 0x20
`define CMF_MB_STRIDE      12'h020
`define CMF_OFS_MODE       5'h00
`define CMF_OFS_MASK       5'h04
`define CMF_OFS_ID         5'h08
`define CMF_OFS_FAMILY     5'h0C
`define CMF_OFS_STATUS     5'h10
`define CMF_OFS_CTRL       5'h14
// controller-wide mode register
`define CMF_ADR_CTRL_MODE  12'h100

// object type codes, mode register bits 26:24
`define CMF_TYPE_LSB       24
`define CMF_OT_DISABLED    3'h0
`define CMF_OT_RX          3'h1
`define CMF_OT_RX_OVWR     3'h2
`define CMF_OT_TX          3'h3
`define CMF_OT_CONSUMER    3'h4
`define CMF_OT_PRODUCER    3'h5

// identifier / mask layout
`define CMF_VER_BIT        29
`define CMF_BASE_MSB       28
`define CMF_BASE_LSB       18
`define CMF_EXT_MSB        17

// status register layout
`define CMF_ST_IGNORED     24
`define CMF_ST_READY       23
`define CMF_ST_ABORT       22
`define CMF_ST_RTR         20
`define CMF_ST_DLC_LSB     16

// control register command bits, dlc field for producers
`define CMF_CT_TRANSFER    23
`define CMF_CT_ABORT       22
`define CMF_CT_DLC_LSB     16

// controller mode register bits
`define CMF_MD_TTM         0
`define CMF_MD_EOF         1

`define CMF_RST_WORD       32'h00000000

`endif

/* File: bench/cmf_mailbox_asserts.sv */
`timescale 1ns/1ps
module cmf_mailbox_asserts #(
  parameter NUM_MB = 8
) (
  input wire       SYS_CLK_I,
  input wire       SRST_I,
  input wire       WE_I,
  input wire       CYC_I,
  input wire       STB_I,
  input wire       ACK_O,
  input wire       RX_VALID_I,
  input wire       TX_DONE_I,
  input wire [2:0] TX_MB_I,
  input wire [7:0] TX_REQ_O,
  input wire [7:0] TX_RTR_O,
  input wire [7:0] MB_READY_O,
  input wire       MB_IRQ_O,
  input wire       RX_STORE_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);
  property p_ack_next;
    CYC_I && STB_I && !ACK_O |=> ACK_O;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse;
    ACK_O |=> !ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_store_cause;
    RX_STORE_O |-> $past(RX_VALID_I, 2);
  endproperty
  a_store_cause: assert property (p_store_cause) else $error("store without frame");
  property p_irq_ready;
    (MB_READY_O != 8'h00) |-> MB_IRQ_O;
  endproperty
  a_irq_ready: assert property (p_irq_ready) else $error("ready without irq");
  property p_done_clears;
    TX_DONE_I && TX_REQ_O[TX_MB_I] |=> !TX_REQ_O[$past(TX_MB_I)];
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("request kept after done");
  property p_done_ready;
    TX_DONE_I && TX_REQ_O[TX_MB_I] && !TX_RTR_O[TX_MB_I] |-> ##2 MB_READY_O[$past(TX_MB_I, 2)];
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("ready not set after send");
  property p_rst_quiet;
    $fell(SRST_I) |-> TX_REQ_O == 8'h00 && MB_READY_O == 8'h00 && !RX_STORE_O && !ACK_O;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
  property p_req_cause;
    (TX_REQ_O & ~$past(TX_REQ_O)) != 8'h00 |-> $past(CYC_I && WE_I) ||
      $past(CYC_I && WE_I, 2) || $past(RX_VALID_I, 2) || $past(RX_VALID_I, 3);
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("request without cause");
  c_store: cover property (RX_STORE_O);
  c_done: cover property (TX_DONE_I && TX_REQ_O[TX_MB_I]);
  c_remote: cover property (TX_RTR_O != 8'h00);
endmodule // cmf_mailbox_asserts

/* File: bench/cmf_core_model.sv */
`timescale 1ns/1ps
module cmf_core_model (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         slow_i,
  input  wire  [7:0]  tx_req_i,
  output logic [15:0] timer_o = 16'h0000,
  output logic        sof_o = 1'h0,
  output logic        rx_valid_o = 1'h0,
  output logic [28:0] rx_id_o = 29'h0,
  output logic        rx_ide_o = 1'h0,
  output logic        rx_rtr_o = 1'h0,
  output logic [3:0]  rx_dlc_o = 4'h0,
  output logic        tx_done_o = 1'h0,
  output logic [2:0]  tx_mb_o = 3'h0
);
  logic [1:0]  tick = 2'h0;
  logic [7:0]  cnt = 8'h00;
  logic [15:0] sof_stamp;
  logic [15:0] eof_stamp;
  // timer steps every fourth cycle so a stamp is stable around frame edges
  always @(posedge clk_i) begin
    tick <= tick + 2'h1;
    if (rst_i) timer_o <= 16'h0000;
    else if (tick == 2'h3) timer_o <= timer_o + 16'h0001;
  end
  always @(posedge clk_i) begin
    tx_done_o <= 1'h0;
    if (rst_i || tx_req_i == 8'h00 || tx_done_o) cnt <= 8'h00;
    else if (cnt >= (slow_i ? 8'h28 : 8'h03)) begin
      cnt <= 8'h00;
      tx_done_o <= 1'h1;
      for (int k = 7; k >= 0; k--) if (tx_req_i[k]) tx_mb_o <= 3'(k);
    end else cnt <= cnt + 8'h01;
  end
  task automatic align();
    while (tick != 2'h0) @(posedge clk_i);
  endtask
  // stamp references at start and end of frame
  task automatic send_frame(input logic [28:0] id, input logic ide, rtr, input logic [3:0] dlc);
    align();
    sof_o <= 1'h1;
    sof_stamp = timer_o;
    @(posedge clk_i);
    sof_o <= 1'h0;
    repeat (6) @(posedge clk_i);
    align();
    rx_valid_o <= 1'h1;
    rx_id_o <= id;
    rx_ide_o <= ide;
    rx_rtr_o <= rtr;
    rx_dlc_o <= dlc;
    eof_stamp = timer_o;
    @(posedge clk_i);
    rx_valid_o <= 1'h0;
    rx_id_o <= ~id;
    rx_dlc_o <= ~dlc;
  endtask
endmodule // cmf_core_model

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`include "cmf_map.vh"
module testbench;
  logic        clk = 1'h0, rst = 1'h1, we = 1'h0, cyc = 1'h0, stb = 1'h0, slow = 1'h0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [3:0]  sel = 4'hF, dlc;
  logic [15:0] tmr;
  logic [28:0] rid;
  logic [2:0]  txmb, smb, last_mb;
  logic [7:0]  req, rreq, rdy;
  logic        ack, sof, rxv, ide, rtr, txd, irq, st;
  int          bad_count = 0, total_checks = 0, cycles = 0, stores = 0;
  cmf_mailbox #(.NUM_MB(8)) DUT (.SYS_CLK_I(clk), .SRST_I(rst), .ADR_I(adr), .DAT_I(wd),
    .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(rdat), .ACK_O(ack),
    .TIMER_I(tmr), .FRAME_SOF_I(sof), .RX_VALID_I(rxv), .RX_ID_I(rid), .RX_IDE_I(ide),
    .RX_RTR_I(rtr), .RX_DLC_I(dlc), .TX_DONE_I(txd), .TX_MB_I(txmb), .TX_REQ_O(req),
    .TX_RTR_O(rreq), .MB_READY_O(rdy), .MB_IRQ_O(irq), .RX_STORE_O(st), .RX_STORE_MB_O(smb));
  cmf_core_model u_core (.clk_i(clk), .rst_i(rst), .slow_i(slow), .tx_req_i(req),
    .timer_o(tmr), .sof_o(sof), .rx_valid_o(rxv), .rx_id_o(rid), .rx_ide_o(ide),
    .rx_rtr_o(rtr), .rx_dlc_o(dlc), .tx_done_o(txd), .tx_mb_o(txmb));
  always #4 clk = ~clk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (st === 1'h1) begin
      stores++;
      last_mb = smb;
    end
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
    chk("bus_ack_drop", 32'(ack), 32'h0);
  endtask
  function automatic logic [11:0] ra(input logic [2:0] n, input logic [4:0] o);
    return {4'h0, n, o};
  endfunction
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m, e);
    wb(1'h0, a, 32'h0);
    chk(nm, q & m, e);
  endtask
  task automatic mb(input logic [2:0] n, input logic [31:0] m, i, input logic [2:0] t);
    wb(1'h1, ra(n, `CMF_OFS_MODE), 32'h0);
    wb(1'h1, ra(n, `CMF_OFS_MASK), m);
    wb(1'h1, ra(n, `CMF_OFS_ID), i);
    wb(1'h1, ra(n, `CMF_OFS_MODE), {5'h00, t, 24'h000000});
  endtask
  task automatic fr(input logic [28:0] i, input logic e, r, input logic [3:0] d,
                    input int ns, input logic [2:0] m);
    int s0 = stores;
    u_core.send_frame(i, e, r, d);
    repeat (4) @(posedge clk);
    chk("stores", 32'(stores - s0), 32'(ns));
    if (ns > 0) chk("store_mb", 32'(last_mb), 32'(m));
  endtask
  // polls the request (s=0) or ready (s=1) output of one mailbox
  task automatic wt(input string nm, input logic s, input logic [2:0] n, input logic v);
    int k = 0;
    while ((s ? rdy[n] : req[n]) !== v && k < 100) begin
      @(posedge clk);
      k++;
    end
    chk(nm, 32'(s ? rdy[n] : req[n]), 32'(v));
  endtask
  task automatic t_regs();
    rdc("st_reset", ra(3'h0, `CMF_OFS_STATUS), 32'hFFFFFFFF, 32'h0);
    mb(3'h0, 32'h20040F0F, 32'h20040C35, `CMF_OT_DISABLED);
    rdc("mask", ra(3'h0, `CMF_OFS_MASK), 32'hFFFFFFFF, 32'h20040F0F);
    rdc("family", ra(3'h0, `CMF_OFS_FAMILY), 32'hFFFFFFFF, 32'h000001C5);
    wb(1'h1, ra(3'h0, `CMF_OFS_ID), 32'hDFFFFFFF);
    rdc("id_std", ra(3'h0, `CMF_OFS_ID), 32'hFFFFFFFF, 32'h1FFC0000);
    rdc("unmapped", 12'h0FC, 32'hFFFFFFFF, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_rx();
    wb(1'h1, `CMF_ADR_CTRL_MODE, 32'h0);
    mb(3'h0, 32'h1FFC0000, 32'h048C0000, `CMF_OT_RX);
    fr({11'h123, 18'h0}, 1'h0, 1'h0, 4'h5, 1, 3'h0);
    rdc("st_rx", ra(3'h0, `CMF_OFS_STATUS), 32'hFFFFFFFF, {16'h0085, u_core.sof_stamp});
    fr({11'h123, 18'h0}, 1'h0, 1'h1, 4'h8, 0, 3'h0);
    rdc("st_full", ra(3'h0, `CMF_OFS_STATUS), 32'hFFFF0000, 32'h01850000);
    rdc("st_reread", ra(3'h0, `CMF_OFS_STATUS), 32'hFFFF0000, 32'h00850000);
    chk("ready_out", {31'h0, rdy[0] & irq}, 32'h1);
    mb(3'h1, 32'h3FFFFFFF, 32'h2556ABCD, `CMF_OT_RX_OVWR);
    fr({11'h155, 18'h2ABCC}, 1'h1, 1'h0, 4'h3, 0, 3'h1);
    fr({11'h155, 18'h2ABCD}, 1'h1, 1'h0, 4'h3, 1, 3'h1);
    wb(1'h1, `CMF_ADR_CTRL_MODE, 32'h2);
    fr({11'h155, 18'h2ABCD}, 1'h1, 1'h1, 4'h7, 1, 3'h1);
    rdc("st_ovwr", ra(3'h1, `CMF_OFS_STATUS), 32'hFFFFFFFF, {16'h0197, u_core.eof_stamp});
    wb(1'h1, `CMF_ADR_CTRL_MODE, 32'h1);
    fr({11'h155, 18'h2ABCD}, 1'h1, 1'h0, 4'h2, 1, 3'h1);
    rdc("st_ttm", ra(3'h1, `CMF_OFS_STATUS), 32'h00FFFFFF, 32'h00820000);
    wb(1'h1, `CMF_ADR_CTRL_MODE, 32'h0);
    mb(3'h2, 32'h1FC00000, 32'h2E951111, `CMF_OT_RX);
    fr({11'h3A0, 18'h0F0F0}, 1'h1, 1'h0, 4'h1, 1, 3'h2);
    $display("test receive done");
  endtask
  task automatic t_off();
    mb(3'h3, 32'h0, 32'h0, `CMF_OT_DISABLED);
    mb(3'h4, 32'h0, 32'h0, 3'h6);
    fr({11'h7FF, 18'h0}, 1'h0, 1'h0, 4'h1, 0, 3'h0);
    wb(1'h1, ra(3'h3, `CMF_OFS_CTRL), 32'h00800000);
    wb(1'h1, ra(3'h4, `CMF_OFS_CTRL), 32'h00800000);
    repeat (3) @(posedge clk);
    chk("req_off", {30'h0, req[4:3]}, 32'h0);
    $display("test disabled done");
  endtask
  task automatic t_tx();
    mb(3'h5, 32'h0, 32'h0, `CMF_OT_TX);
    slow <= 1'h1;
    wb(1'h1, ra(3'h5, `CMF_OFS_CTRL), 32'h00800000);
    wt("tx_req", 1'h0, 3'h5, 1'h1);
    rdc("st_busy", ra(3'h5, `CMF_OFS_STATUS), 32'h00C00000, 32'h0);
    wb(1'h1, ra(3'h5, `CMF_OFS_CTRL), 32'h00400000);
    wt("tx_abort", 1'h0, 3'h5, 1'h0);
    rdc("st_abort", ra(3'h5, `CMF_OFS_STATUS), 32'h00C00000, 32'h00400000);
    slow <= 1'h0;
    wb(1'h1, ra(3'h5, `CMF_OFS_CTRL), 32'h00800000);
    wt("tx_sent", 1'h1, 3'h5, 1'h1);
    rdc("st_sent", ra(3'h5, `CMF_OFS_STATUS), 32'h00C00000, 32'h00800000);
    $display("test transmit done");
  endtask
  task automatic t_pair();
    mb(3'h6, 32'h1FFC0000, 32'h0AC80000, `CMF_OT_CONSUMER);
    rdc("st_cons", ra(3'h6, `CMF_OFS_STATUS), 32'h00900000, 32'h00100000);
    slow <= 1'h1;
    wb(1'h1, ra(3'h6, `CMF_OFS_CTRL), 32'h00800000);
    wt("cons_req", 1'h0, 3'h6, 1'h1);
    chk("cons_remote", 32'(rreq[6]), 32'h1);
    slow <= 1'h0;
    wt("cons_sent", 1'h0, 3'h6, 1'h0);
    chk("cons_wait", 32'(rdy[6]), 32'h0);
    fr({11'h2B2, 18'h0}, 1'h0, 1'h0, 4'h6, 1, 3'h6);
    rdc("st_cdata", ra(3'h6, `CMF_OFS_STATUS), 32'h008F0000, 32'h00860000);
    mb(3'h4, 32'h1FFC0000, 32'h0F0C0000, `CMF_OT_PRODUCER);
    rdc("st_prod", ra(3'h4, `CMF_OFS_STATUS), 32'h00900000, 32'h00800000);
    wb(1'h1, ra(3'h4, `CMF_OFS_CTRL), 32'h008A0000);
    repeat (5) @(posedge clk);
    chk("prod_idle", 32'(req[4]), 32'h0);
    u_core.send_frame({11'h3C3, 18'h0}, 1'h0, 1'h1, 4'h0);
    wt("prod_req", 1'h0, 3'h4, 1'h1);
    wt("prod_sent", 1'h1, 3'h4, 1'h1);
    rdc("st_pdata", ra(3'h4, `CMF_OFS_STATUS), 32'h008F0000, 32'h008A0000);
    $display("test consumer producer done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_regs();
    t_rx();
    t_off();
    t_tx();
    t_pair();
    stop_test();
  end
endmodule // testbench
bind cmf_mailbox cmf_mailbox_asserts #(.NUM_MB(NUM_MB)) u_chk (.SYS_CLK_I(SYS_CLK_I),
  .SRST_I(SRST_I), .WE_I(WE_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
  .RX_VALID_I(RX_VALID_I), .TX_DONE_I(TX_DONE_I), .TX_MB_I(TX_MB_I), .TX_REQ_O(TX_REQ_O),
  .TX_RTR_O(TX_RTR_O), .MB_READY_O(MB_READY_O), .MB_IRQ_O(MB_IRQ_O), .RX_STORE_O(RX_STORE_O));
